// [bbx_pkg.sv]
/*
 * Shared constants and types for the branch and bit-operation executor:
 * operation codes, status flag positions, cycle counts, register offsets.
 * Assumes an upstream decoder that presents one decoded operation at a time.
 */
`default_nettype none

package bbx_pkg;

	// ----------------------------------------------------------------
	// Widths and status flag positions
	// ----------------------------------------------------------------
	localparam int PC_W = 16;
	localparam int OFS_W = 12;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] CORE_FLAG_REGISTER_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Cycle counts per operation
	// ----------------------------------------------------------------
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_REL_JUMP = 3'h2;
	localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
	localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
	localparam logic [2:0] CYC_REL_CALL = 3'h4;
	localparam logic [2:0] CYC_PTR_CALL = 3'h4;
	localparam logic [2:0] CYC_ABS_CALL = 3'h5;
	localparam logic [2:0] CYC_RETURN = 3'h5;
	localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
	localparam logic [2:0] CYC_SKIP_LONG = 3'h3;
	localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
	localparam logic [2:0] CYC_IO_BIT = 3'h2;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
	localparam logic [PC_W-1:0] PC_SKIP_SHORT = 16'h0002;
	localparam logic [PC_W-1:0] PC_SKIP_LONG = 16'h0003;

	// ----------------------------------------------------------------
	// Register port offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_PC = 4'h0;
	localparam logic [3:0] REG_FLAGS = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;

	typedef enum logic [5:0] {
		relative_jump_op = 6'h00, pointer_jump_op = 6'h01, absolute_jump_op = 6'h02,
		relative_call_op = 6'h03, pointer_call_op = 6'h04, absolute_call_op = 6'h05,
		subroutine_return_op = 6'h06, interrupt_return_op = 6'h07,
		compare_skip_equal_op = 6'h08, compare_reg_op = 6'h09, compare_carry_op = 6'h0a,
		compare_immediate_op = 6'h0b, skip_reg_bit_clear_op = 6'h0c,
		skip_reg_bit_set_op = 6'h0d, skip_io_bit_clear_op = 6'h0e, skip_io_bit_set_op = 6'h0f,
		branch_flag_set_op = 6'h10, branch_flag_clear_op = 6'h11, branch_equal_op = 6'h12,
		branch_not_equal_op = 6'h13, branch_carry_set_op = 6'h14,
		branch_carry_clear_op = 6'h15, branch_same_higher_op = 6'h16, branch_lower_op = 6'h17,
		branch_minus_op = 6'h18, branch_plus_op = 6'h19, branch_signed_ge_op = 6'h1a,
		branch_signed_lt_op = 6'h1b, branch_halfcarry_set_op = 6'h1c,
		branch_halfcarry_clear_op = 6'h1d, branch_transfer_set_op = 6'h1e,
		branch_transfer_clear_op = 6'h1f, branch_overflow_set_op = 6'h20,
		branch_overflow_clear_op = 6'h21, branch_irq_enabled_op = 6'h22,
		branch_irq_disabled_op = 6'h23, io_bit_set_op = 6'h24, io_bit_clear_op = 6'h25,
		shift_left_logical_op = 6'h26, shift_right_logical_op = 6'h27,
		rotate_left_carry_op = 6'h28, rotate_right_carry_op = 6'h29,
		shift_right_arith_op = 6'h2a, nibble_swap_op = 6'h2b, indexed_flag_set_op = 6'h2c,
		indexed_flag_clear_op = 6'h2d, bit_to_transfer_flag_op = 6'h2e,
		transfer_flag_to_bit_op = 6'h2f, carry_set_op = 6'h30, carry_clear_op = 6'h31
	} bbx_op_e;

	typedef struct packed {
		bbx_op_e op;
		logic [7:0] rd_val;
		logic [7:0] rr_val;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [OFS_W-1:0] offset;
		logic [PC_W-1:0] target;
	} bbx_instr_s;

endpackage : bbx_pkg

`default_nettype wire

// [bbx_shift_unit.sv]
/*
 * Shift, rotate and nibble swap datapath with its flag results.
 * Assumes the caller only uses the flags for the shift and rotate kinds.
 */
`timescale 1ns/1ps
`default_nettype none

module bbx_shift_unit
	import bbx_pkg::*;
(
	input wire bbx_op_e i_op,
	input wire logic [7:0] i_value,
	input wire logic i_carry,
	output logic [7:0] o_result,
	output logic o_carry,
	output logic o_zero,
	output logic o_negative,
	output logic o_overflow
);

	always_comb
	begin
		o_result = i_value;
		o_carry = i_carry;
		unique case (i_op)
			shift_left_logical_op:
			begin
				o_result = {i_value[6:0], 1'b0};
				o_carry = i_value[7];
			end
			rotate_left_carry_op:
			begin
				o_result = {i_value[6:0], i_carry};
				o_carry = i_value[7];
			end
			shift_right_logical_op:
			begin
				o_result = {1'b0, i_value[7:1]};
				o_carry = i_value[0];
			end
			rotate_right_carry_op:
			begin
				o_result = {i_carry, i_value[7:1]};
				o_carry = i_value[0];
			end
			shift_right_arith_op:
			begin
				o_result = {i_value[7], i_value[7:1]};
				o_carry = i_value[0];
			end
			nibble_swap_op:
				o_result = {i_value[3:0], i_value[7:4]};
			default:
				o_result = i_value;
		endcase
		o_zero = (o_result == 8'h00);
		o_negative = o_result[7];
		// Overflow here is defined as negative xor carry after the shift
		o_overflow = o_result[7] ^ o_carry;
	end

endmodule : bbx_shift_unit

`default_nettype wire

// [bbx_cond_unit.sv]
/*
 * Condition evaluation for conditional branches and skips.
 * Assumes flag and operand inputs are stable in the cycle the op is offered.
 */
`timescale 1ns/1ps
`default_nettype none

module bbx_cond_unit
	import bbx_pkg::*;
(
	input wire bbx_op_e i_op,
	input wire logic [7:0] i_core_flag_register,
	input wire logic [7:0] i_rd_val,
	input wire logic [7:0] i_rr_val,
	input wire logic [7:0] i_io_val,
	input wire logic [2:0] i_bit_sel,
	output logic o_is_branch,
	output logic o_is_skip,
	output logic o_hit
);

	always_comb
	begin
		o_is_branch = 1'b1;
		o_is_skip = 1'b0;
		o_hit = 1'b0;
		unique case (i_op)
			branch_flag_set_op: o_hit = i_core_flag_register[i_bit_sel];
			branch_flag_clear_op: o_hit = ~i_core_flag_register[i_bit_sel];
			branch_equal_op: o_hit = i_core_flag_register[FLAG_Z];
			branch_not_equal_op: o_hit = ~i_core_flag_register[FLAG_Z];
			branch_carry_set_op, branch_lower_op: o_hit = i_core_flag_register[FLAG_C];
			branch_carry_clear_op, branch_same_higher_op: o_hit = ~i_core_flag_register[FLAG_C];
			branch_minus_op: o_hit = i_core_flag_register[FLAG_N];
			branch_plus_op: o_hit = ~i_core_flag_register[FLAG_N];
			branch_signed_ge_op: o_hit = ~(i_core_flag_register[FLAG_N] ^ i_core_flag_register[FLAG_V]);
			branch_signed_lt_op: o_hit = i_core_flag_register[FLAG_N] ^ i_core_flag_register[FLAG_V];
			branch_halfcarry_set_op: o_hit = i_core_flag_register[FLAG_H];
			branch_halfcarry_clear_op: o_hit = ~i_core_flag_register[FLAG_H];
			branch_overflow_set_op: o_hit = i_core_flag_register[FLAG_V];
			branch_overflow_clear_op: o_hit = ~i_core_flag_register[FLAG_V];
			branch_transfer_set_op: o_hit = i_core_flag_register[FLAG_T];
			branch_transfer_clear_op: o_hit = ~i_core_flag_register[FLAG_T];
			branch_irq_enabled_op: o_hit = i_core_flag_register[FLAG_I];
			branch_irq_disabled_op: o_hit = ~i_core_flag_register[FLAG_I];
			compare_skip_equal_op:
			begin
				o_is_branch = 1'b0;
				o_is_skip = 1'b1;
				o_hit = (i_rd_val == i_rr_val);
			end
			skip_reg_bit_clear_op, skip_reg_bit_set_op:
			begin
				o_is_branch = 1'b0;
				o_is_skip = 1'b1;
				o_hit = i_rr_val[i_bit_sel] ^ (i_op == skip_reg_bit_clear_op);
			end
			skip_io_bit_clear_op, skip_io_bit_set_op:
			begin
				o_is_branch = 1'b0;
				o_is_skip = 1'b1;
				o_hit = i_io_val[i_bit_sel] ^ (i_op == skip_io_bit_clear_op);
			end
			default:
				o_is_branch = 1'b0;
		endcase
	end

endmodule : bbx_cond_unit

`default_nettype wire

// [bbx_executor.sv]
/* Executor for control-flow, compare, skip, branch and bit operations; holds
 * the program counter and the core flag register. Assumes a decoder offering one
 * decoded op with operands, and I/O and stack fabric answering in that cycle. */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Calls: relative and pointer take 4 cycles, absolute 5; flags kept.
// - Compare-skip-equal skips next op on match; 1/2/3 cycles; flags kept.
// - Compares subtract without writeback, update Z N V C H in one cycle.
// - Register-bit skips test bit clear or set; 1/2/3 cycles; flags kept.
// - I/O-bit skips test bit clear or set; 1/2/3 cycles; flags kept.
// - Generic branches test selected flag bit; 1 cycle untaken, 2 taken.
// - Signed ge taken on N xor V zero, signed lt on one.
// - Equal tests Z, carry-style branches test C, minus and plus test N.
// - Half-carry and overflow branches, same offset and timing.
// - Transfer-flag branches jump to PC plus offset plus one.
// - Interrupt-state branches test the global enable; flags kept.
// - I/O bit set and clear force one bit, take 2 cycles.
// - Left rotate through carry and logical left shift update Z C N V.
// - Right rotate, logical and arithmetic right shifts update Z C N V.
// - Bit store copies into T; bit load copies T into register bit.
// - Nibble swap exchanges halves; indexed flag set and clear in one cycle.
module bbx_executor
	import bbx_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_op_valid,
	input wire bbx_instr_s i_instr,
	input wire logic [PC_W-1:0] i_z_ptr,
	input wire logic i_next_two_word,
	input wire logic [7:0] i_io_rdata,
	input wire logic [PC_W-1:0] i_stack_pc,
	output logic o_op_ready,
	output logic [PC_W-1:0] o_pc,
	output logic [7:0] o_core_flag_register,
	output logic o_reg_we,
	output logic [7:0] o_reg_wdata,
	output logic o_io_we,
	output logic [7:0] o_io_wdata,
	output logic o_stack_push,
	output logic [PC_W-1:0] o_push_pc,
	output logic o_stack_pop,
	input wire logic [3:0] i_bus_addr,
	input wire logic [15:0] i_bus_wdata,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	output logic [15:0] o_bus_rdata
);

	typedef enum logic [1:0] {st_idle = 2'b01, st_busy = 2'b10} bbx_state_e;

	bbx_state_e state_q;
	logic [2:0] wait_q, ncyc;
	logic [PC_W-1:0] pc_q, pc_d, push_pc_d, rel_pc, seq_pc;
	logic [7:0] core_flag_register_q, core_flag_register_d, res_d, io_d, sh_res, cmp_b, cmp_r;
	logic accept, res_we_d, io_we_d, push_d, pop_d, is_branch, is_skip, hit;
	logic sh_c, sh_z, sh_n, sh_v, cmp_cin;
	logic [8:0] cmp_diff;

	assign o_op_ready = (state_q == st_idle);
	assign accept = i_op_valid && o_op_ready;
	assign o_pc = pc_q;
	assign o_core_flag_register = core_flag_register_q;
	assign seq_pc = pc_q + PC_STEP;
	assign rel_pc = pc_q + PC_W'({{(PC_W-OFS_W){i_instr.offset[OFS_W-1]}}, i_instr.offset})
		+ PC_STEP;

	bbx_cond_unit u_cond (
		.i_op(i_instr.op),
		.i_core_flag_register(core_flag_register_q),
		.i_rd_val(i_instr.rd_val),
		.i_rr_val(i_instr.rr_val),
		.i_io_val(i_io_rdata),
		.i_bit_sel(i_instr.bit_sel),
		.o_is_branch(is_branch),
		.o_is_skip(is_skip),
		.o_hit(hit)
	);

	bbx_shift_unit u_shift (
		.i_op(i_instr.op),
		.i_value(i_instr.rd_val),
		.i_carry(core_flag_register_q[FLAG_C]),
		.o_result(sh_res),
		.o_carry(sh_c),
		.o_zero(sh_z),
		.o_negative(sh_n),
		.o_overflow(sh_v)
	);

	// ----------------------------------------------------------------
	// Compare datapath
	// ----------------------------------------------------------------
	assign cmp_b = (i_instr.op == compare_immediate_op) ? i_instr.imm : i_instr.rr_val;
	assign cmp_cin = (i_instr.op == compare_carry_op) && core_flag_register_q[FLAG_C];
	assign cmp_diff = {1'b0, i_instr.rd_val} - {1'b0, cmp_b} - {8'h00, cmp_cin};
	assign cmp_r = cmp_diff[7:0];

	// ----------------------------------------------------------------
	// Next architectural state
	// ----------------------------------------------------------------
	always_comb
	begin
		pc_d = seq_pc;
		core_flag_register_d = core_flag_register_q;
		ncyc = CYC_ONE;
		res_d = i_instr.rd_val;
		res_we_d = 1'b0;
		io_d = i_io_rdata;
		io_we_d = 1'b0;
		push_d = 1'b0;
		pop_d = 1'b0;
		push_pc_d = seq_pc;
		if (is_branch && hit)
		begin
			pc_d = rel_pc;
			ncyc = CYC_BR_TAKEN;
		end
		if (is_skip && hit)
		begin
			// Skip length follows the width of the op being skipped
			pc_d = pc_q + (i_next_two_word ? PC_SKIP_LONG : PC_SKIP_SHORT);
			ncyc = i_next_two_word ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
		end
		unique case (i_instr.op)
			relative_jump_op:
			begin
				pc_d = rel_pc;
				ncyc = CYC_REL_JUMP;
			end
			pointer_jump_op:
			begin
				pc_d = i_z_ptr;
				ncyc = CYC_PTR_JUMP;
			end
			absolute_jump_op:
			begin
				pc_d = i_instr.target;
				ncyc = CYC_ABS_JUMP;
			end
			relative_call_op:
			begin
				pc_d = rel_pc;
				push_d = 1'b1;
				ncyc = CYC_REL_CALL;
			end
			pointer_call_op:
			begin
				pc_d = i_z_ptr;
				push_d = 1'b1;
				ncyc = CYC_PTR_CALL;
			end
			absolute_call_op:
			begin
				// Two-word op, so the return point is two words on
				pc_d = i_instr.target;
				push_d = 1'b1;
				push_pc_d = pc_q + PC_SKIP_SHORT;
				ncyc = CYC_ABS_CALL;
			end
			subroutine_return_op:
			begin
				pc_d = i_stack_pc;
				pop_d = 1'b1;
				ncyc = CYC_RETURN;
			end
			interrupt_return_op:
			begin
				pc_d = i_stack_pc;
				pop_d = 1'b1;
				core_flag_register_d[FLAG_I] = 1'b1;
				ncyc = CYC_RETURN;
			end
			compare_reg_op, compare_carry_op, compare_immediate_op:
			begin
				core_flag_register_d[FLAG_C] = cmp_diff[8];
				core_flag_register_d[FLAG_N] = cmp_r[7];
				core_flag_register_d[FLAG_V] = (i_instr.rd_val[7] & ~cmp_b[7] & ~cmp_r[7])
					| (~i_instr.rd_val[7] & cmp_b[7] & cmp_r[7]);
				core_flag_register_d[FLAG_H] = (~i_instr.rd_val[3] & cmp_b[3]) | (cmp_b[3] & cmp_r[3])
					| (cmp_r[3] & ~i_instr.rd_val[3]);
				// With carry the zero flag can only stay or fall, for multi-byte chains
				core_flag_register_d[FLAG_Z] = (cmp_r == 8'h00)
					&& ((i_instr.op != compare_carry_op) || core_flag_register_q[FLAG_Z]);
				core_flag_register_d[FLAG_S] = core_flag_register_d[FLAG_N] ^ core_flag_register_d[FLAG_V];
			end
			io_bit_set_op, io_bit_clear_op:
			begin
				io_d[i_instr.bit_sel] = (i_instr.op == io_bit_set_op);
				io_we_d = 1'b1;
				ncyc = CYC_IO_BIT;
			end
			shift_left_logical_op, rotate_left_carry_op, shift_right_logical_op,
			rotate_right_carry_op, shift_right_arith_op:
			begin
				res_d = sh_res;
				res_we_d = 1'b1;
				core_flag_register_d[FLAG_C] = sh_c;
				core_flag_register_d[FLAG_Z] = sh_z;
				core_flag_register_d[FLAG_N] = sh_n;
				core_flag_register_d[FLAG_V] = sh_v;
				core_flag_register_d[FLAG_S] = sh_n ^ sh_v;
			end
			nibble_swap_op:
			begin
				res_d = sh_res;
				res_we_d = 1'b1;
			end
			indexed_flag_set_op: core_flag_register_d[i_instr.bit_sel] = 1'b1;
			indexed_flag_clear_op: core_flag_register_d[i_instr.bit_sel] = 1'b0;
			bit_to_transfer_flag_op: core_flag_register_d[FLAG_T] = i_instr.rd_val[i_instr.bit_sel];
			transfer_flag_to_bit_op:
			begin
				res_d[i_instr.bit_sel] = core_flag_register_q[FLAG_T];
				res_we_d = 1'b1;
			end
			carry_set_op: core_flag_register_d[FLAG_C] = 1'b1;
			carry_clear_op: core_flag_register_d[FLAG_C] = 1'b0;
			default: core_flag_register_d = core_flag_register_q;
		endcase
	end

	// ----------------------------------------------------------------
	// Occupancy: an op holds the executor for its cycle count
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q <= st_idle;
			wait_q <= 3'h0;
		end
		else if (accept && (ncyc != CYC_ONE))
		begin
			state_q <= st_busy;
			wait_q <= ncyc - CYC_REL_JUMP;
		end
		else if (state_q == st_busy)
		begin
			if (wait_q == 3'h0)
				state_q <= st_idle;
			else
				wait_q <= wait_q - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Program counter and flags; an op wins over a same-cycle bus write
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			pc_q <= PC_RESET;
		else if (accept)
			pc_q <= pc_d;
		else if (i_bus_wr && (i_bus_addr == REG_PC))
			pc_q <= i_bus_wdata;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			core_flag_register_q <= CORE_FLAG_REGISTER_RESET;
		else if (accept)
			core_flag_register_q <= core_flag_register_d;
		else if (i_bus_wr && (i_bus_addr == REG_FLAGS))
			core_flag_register_q <= i_bus_wdata[7:0];
	end

	// ----------------------------------------------------------------
	// Side-effect strobes, one cycle after acceptance
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_reg_we <= 1'b0;
			o_reg_wdata <= 8'h00;
			o_io_we <= 1'b0;
			o_io_wdata <= 8'h00;
			o_stack_push <= 1'b0;
			o_push_pc <= PC_RESET;
			o_stack_pop <= 1'b0;
		end
		else
		begin
			o_reg_we <= accept && res_we_d;
			o_io_we <= accept && io_we_d;
			o_stack_push <= accept && push_d;
			o_stack_pop <= accept && pop_d;
			if (accept)
			begin
				o_reg_wdata <= res_d;
				o_io_wdata <= io_d;
				o_push_pc <= push_pc_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register port read
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_bus_rdata <= 16'h0000;
		else if (i_bus_rd)
			unique case (i_bus_addr)
				REG_PC: o_bus_rdata <= pc_q;
				REG_FLAGS: o_bus_rdata <= {8'h00, core_flag_register_q};
				REG_STATUS: o_bus_rdata <= {13'h0000, wait_q[1:0], (state_q == st_busy)};
				default: o_bus_rdata <= 16'h0000;
			endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_busy_one;
		!o_op_ready ##1 o_op_ready;
	endsequence

	a_rel_call_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == relative_call_op) |=> !o_op_ready [*3] ##1 o_op_ready)
		else $error("relative call did not take four cycles");
	a_abs_call_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == absolute_call_op)
		|=> (!o_op_ready && o_stack_push) ##1 !o_op_ready [*3] ##1 o_op_ready)
		else $error("absolute call did not take five cycles");
	a_return_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == interrupt_return_op)
		|=> o_core_flag_register[FLAG_I] && o_stack_pop ##0 !o_op_ready [*4] ##1 o_op_ready)
		else $error("interrupt return timing or enable flag wrong");
	a_jump_abs_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == absolute_jump_op)
		|=> (o_pc == $past(i_instr.target)) && !o_op_ready ##1 s_busy_one)
		else $error("absolute jump target or timing wrong");
	a_branch_taken: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && is_branch && hit |=> (o_pc == $past(rel_pc)) ##0 s_busy_one)
		else $error("taken branch target or timing wrong");
	a_branch_flags: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && is_branch |=> o_core_flag_register == $past(o_core_flag_register))
		else $error("branch altered the flags");
	a_skip_long: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && is_skip && hit && i_next_two_word
		|=> (o_pc == $past(o_pc) + PC_SKIP_LONG) ##0 !o_op_ready [*2] ##1 o_op_ready)
		else $error("long skip target or timing wrong");
	a_compare_nowrite: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == compare_reg_op) |=> !o_reg_we && o_op_ready
		&& (o_core_flag_register[FLAG_Z] == ($past(i_instr.rd_val) == $past(i_instr.rr_val))))
		else $error("compare wrote back or zero flag wrong");
	a_io_bit_force: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == io_bit_set_op)
		|=> o_io_we && o_io_wdata[$past(i_instr.bit_sel)] ##0 s_busy_one)
		else $error("io bit set wrong");
	a_transfer_store: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		accept && (i_instr.op == bit_to_transfer_flag_op)
		|=> o_core_flag_register[FLAG_T] == $past(i_instr.rd_val[i_instr.bit_sel]))
		else $error("bit store to transfer flag wrong");

endmodule : bbx_executor

`default_nettype wire

// [tb.sv]
/* Random and corner-case bench for the branch and bit-operation executor.
   Assumes one decoded op at a time and the register port offsets of the package. */
`timescale 1ns/1ps
`default_nettype none
module tb
	import bbx_pkg::*;
;
	logic i_ref_clk = 1'h0, i_reset_n = 1'h0, i_op_valid = 1'h0, i_next_two_word = 1'h0;
	logic i_bus_wr = 1'h0, i_bus_rd = 1'h0, o_op_ready, o_reg_we, o_io_we, o_stack_push, o_stack_pop;
	bbx_instr_s i_instr = '0, x;
	logic [15:0] i_z_ptr = 16'h0, i_stack_pc = 16'h0, i_bus_wdata = 16'h0, o_pc, o_push_pc;
	logic [15:0] o_bus_rdata, e_pc, p, z, stk;
	logic [7:0] i_io_rdata = 8'h0, o_core_flag_register, o_reg_wdata, o_io_wdata, e_sr, e_d, s, io, r;
	logic [3:0] i_bus_addr = 4'h0;
	logic [63:0] w;
	logic two, c, hit;
	logic [1:0] e_st;
	int fail_count = 0, compares = 0, cyc = 0, e_n, e_k, n;
	bbx_executor i_dut (.i_ref_clk, .i_reset_n, .i_op_valid, .i_instr, .i_z_ptr, .i_next_two_word,
		.i_io_rdata, .i_stack_pc, .o_op_ready, .o_pc, .o_core_flag_register, .o_reg_we, .o_reg_wdata, .o_io_we,
		.o_io_wdata, .o_stack_push, .o_push_pc, .o_stack_pop, .i_bus_addr, .i_bus_wdata,
		.i_bus_wr, .i_bus_rd, .o_bus_rdata);
	initial forever #20 i_ref_clk = ~i_ref_clk;
	task chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t op %s got %h want %h", $time, x.op.name(), g, e);
		end
	endtask : chk
	task end_of_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// Generous ceiling: the op loop needs well under 10000 cycles
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	task bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_bus_wr <= wr;
		i_bus_rd <= !wr;
		i_bus_addr <= a;
		i_bus_wdata <= d;
		@(posedge i_ref_clk);
		i_bus_wr <= 1'h0;
		i_bus_rd <= 1'h0;
		#1;
	endtask : bus
	// ----------------------------------------------------------------
	// Expectation
	// ----------------------------------------------------------------
	task go(input logic [15:0] pc, input int k);
		e_pc = pc;
		e_n = k;
	endtask : go
	task put(input logic [7:0] d);
		e_d = d;
		e_k = 1;
	endtask : put
	function automatic logic bor(input logic a, input logic b, input logic d);
		return (!a && b) || (b && d) || (d && !a);
	endfunction : bor
	task model;
		logic [15:0] rel;
		logic [7:0] b;
		rel = p + {{4{x.offset[11]}}, x.offset} + 16'h1;
		b = (x.op == compare_immediate_op) ? x.imm : x.rr_val;
		go(p + 16'h1, 1);
		e_sr = s;
		e_k = 0;
		hit = 1'h0;
		e_st[1] = x.op inside {[relative_call_op:absolute_call_op]};
		e_st[0] = x.op inside {[subroutine_return_op:interrupt_return_op]};
		case (x.op)
			relative_jump_op: go(rel, 2);
			pointer_jump_op: go(z, 2);
			absolute_jump_op: go(x.target, 3);
			relative_call_op: go(rel, 4);
			pointer_call_op: go(z, 4);
			absolute_call_op: go(x.target, 5);
			subroutine_return_op, interrupt_return_op: go(stk, 5);
			compare_skip_equal_op: hit = x.rd_val == x.rr_val;
			skip_reg_bit_clear_op, skip_reg_bit_set_op: hit = x.rr_val[x.bit_sel] ^ !x.op[0];
			skip_io_bit_clear_op, skip_io_bit_set_op: hit = io[x.bit_sel] ^ !x.op[0];
			branch_flag_set_op, branch_flag_clear_op: hit = s[x.bit_sel] ^ x.op[0];
			branch_equal_op, branch_not_equal_op: hit = s[FLAG_Z] ^ x.op[0];
			branch_carry_set_op, branch_carry_clear_op: hit = s[FLAG_C] ^ x.op[0];
			branch_same_higher_op, branch_lower_op: hit = s[FLAG_C] ^ !x.op[0];
			branch_minus_op, branch_plus_op: hit = s[FLAG_N] ^ x.op[0];
			branch_signed_ge_op, branch_signed_lt_op: hit = s[FLAG_N] ^ s[FLAG_V] ^ !x.op[0];
			branch_halfcarry_set_op, branch_halfcarry_clear_op: hit = s[FLAG_H] ^ x.op[0];
			branch_transfer_set_op, branch_transfer_clear_op: hit = s[FLAG_T] ^ x.op[0];
			branch_overflow_set_op, branch_overflow_clear_op: hit = s[FLAG_V] ^ x.op[0];
			branch_irq_enabled_op, branch_irq_disabled_op: hit = s[FLAG_I] ^ x.op[0];
			io_bit_set_op, io_bit_clear_op:
			begin
				e_d = io;
				e_d[x.bit_sel] = !x.op[0];
				go(p + 16'h1, 2);
				e_k = 2;
			end
			shift_left_logical_op, rotate_left_carry_op:
				{c, r} = {x.rd_val, x.op == rotate_left_carry_op && s[FLAG_C]};
			shift_right_logical_op, rotate_right_carry_op, shift_right_arith_op:
				{r, c} = {x.op == rotate_right_carry_op ? s[FLAG_C] :
					x.op == shift_right_arith_op && x.rd_val[7], x.rd_val};
			nibble_swap_op: put({x.rd_val[3:0], x.rd_val[7:4]});
			transfer_flag_to_bit_op:
				put(x.rd_val & ~(8'h1 << x.bit_sel) | {7'h0, s[FLAG_T]} << x.bit_sel);
			bit_to_transfer_flag_op: e_sr[FLAG_T] = x.rd_val[x.bit_sel];
			indexed_flag_set_op, indexed_flag_clear_op: e_sr[x.bit_sel] = !x.op[0];
			carry_set_op, carry_clear_op: e_sr[FLAG_C] = !x.op[0];
			compare_reg_op, compare_carry_op, compare_immediate_op:
			begin
				r = x.rd_val - b - 8'(x.op == compare_carry_op && s[FLAG_C]);
				e_sr[FLAG_C] = bor(x.rd_val[7], b[7], r[7]);
				e_sr[FLAG_H] = bor(x.rd_val[3], b[3], r[3]);
				e_sr[FLAG_V] = x.rd_val[7] != b[7] && r[7] != x.rd_val[7];
				e_sr[FLAG_N] = r[7];
				e_sr[FLAG_S] = r[7] ^ e_sr[FLAG_V];
				e_sr[FLAG_Z] = r == 8'h0 && (x.op != compare_carry_op || s[FLAG_Z]);
			end
			default: ;
		endcase
		if (x.op == interrupt_return_op)
			e_sr[FLAG_I] = 1'h1;
		if (hit && x.op < branch_flag_set_op)
			go(p + (two ? PC_SKIP_LONG : PC_SKIP_SHORT), two ? 3 : 2);
		else if (hit)
			go(rel, 2);
		if (x.op inside {[shift_left_logical_op:shift_right_arith_op]})
		begin
			put(r);
			e_sr[FLAG_C] = c;
			e_sr[FLAG_Z] = r == 8'h0;
			e_sr[FLAG_N] = r[7];
			e_sr[FLAG_V] = r[7] ^ c;
			e_sr[FLAG_S] = c;
		end
	endtask : model
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h842b7524));
		repeat (2) @(posedge i_ref_clk);
		i_reset_n <= 1'h1;
		#1;
		chk(o_pc, PC_RESET);
		chk({8'h0, o_core_flag_register}, {8'h0, CORE_FLAG_REGISTER_RESET});
		bus(1'h0, 4'hc, 16'h0);
		chk(o_bus_rdata, 16'h0);
		bus(1'h1, REG_FLAGS, 16'h00a5);
		bus(1'h0, REG_FLAGS, 16'h0);
		chk(o_bus_rdata, 16'h00a5);
		for (int k = 0; k < 400; k++)
		begin
			w = {$urandom, $urandom};
			x = w[60:0];
			x.op = bbx_op_e'(6'(k % 50));
			x.offset = 12'($signed(7'($urandom)));
			{p, z, stk} = 48'({$urandom, $urandom});
			{s, io, two} = 17'($urandom);
			// Corners: equal operands, most negative short offset
			if (k < 50)
				{x.rr_val, x.offset} = {x.rd_val, 12'hfc0};
			bus(1'h1, REG_PC, p);
			bus(1'h1, REG_FLAGS, {8'h0, s});
			model;
			@(posedge i_ref_clk);
			i_op_valid <= 1'h1;
			i_instr <= x;
			{i_z_ptr, i_stack_pc, i_io_rdata, i_next_two_word} <= {z, stk, io, two};
			@(posedge i_ref_clk);
			i_op_valid <= 1'h0;
			#1;
			chk(o_pc, e_pc);
			chk({8'h0, o_core_flag_register}, {8'h0, e_sr});
			if (e_k == 2)
				chk({7'h0, o_io_we, o_io_wdata}, {8'h1, e_d});
			else if (e_k != 0)
				chk({7'h0, o_reg_we, o_reg_wdata}, {8'h1, e_d});
			else
				chk({14'h0, o_reg_we, o_io_we}, 16'h0);
			chk({14'h0, o_stack_push, o_stack_pop}, {14'h0, e_st});
			if (e_st[1])
				chk(o_push_pc, p + (x.op == absolute_call_op ? PC_SKIP_SHORT : PC_STEP));
			n = 1;
			while (o_op_ready !== 1'h1 && n < 9)
			begin
				@(posedge i_ref_clk);
				#1;
				n++;
			end
			chk(16'(n), 16'(e_n));
		end
		// Register port reads while a five-cycle call still holds the executor
		x.op = absolute_call_op;
		@(posedge i_ref_clk);
		i_op_valid <= 1'h1;
		i_instr <= x;
		@(posedge i_ref_clk);
		i_op_valid <= 1'h0;
		bus(1'h0, REG_STATUS, 16'h0);
		chk(o_bus_rdata, 16'h0005);
		bus(1'h0, REG_PC, 16'h0);
		chk(o_bus_rdata, x.target);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
